// *** design/led_sink_pkg.sv ***
package led_sink_pkg;
   // channel count of one device
   localparam int unsigned CHANNELS = 16;
   // system clock period in picoseconds (250 MHz)
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // unit stagger step between successive channels, in picoseconds
   localparam int unsigned STAGGER_STEP_PS = 5000;
   // stagger step in clock cycles, rounded down, never below one
   localparam int unsigned STAGGER_STEP_CYC =
      (STAGGER_STEP_PS / CLK_PERIOD_PS) < 1 ? 1 : (STAGGER_STEP_PS / CLK_PERIOD_PS);
   // shortest serial shift clock period the controller may use (25 MHz), in picoseconds
   localparam int unsigned SHIFT_CLK_MIN_PERIOD_PS = 40000;
   // reset values
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [15:0] LATCH_RESET = 16'h0000;
   // switching order: slot k switches channel order[k] to its target level
   localparam logic [3:0] STAGGER_ORDER [16] = '{
      4'h0, 4'hF, 4'h1, 4'hE, 4'h2, 4'hD, 4'h3, 4'hC,
      4'h4, 4'hB, 4'h5, 4'hA, 4'h6, 4'h9, 4'h7, 4'h8};
endpackage

// *** design/skid_buffer.sv ***
`timescale 1ns/1ps
// two-entry buffer: a stall on the drain side loses no word
module skid_buffer #(
   parameter int unsigned WIDTH = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   // all state in one struct
   typedef struct packed {
      logic [1:0] count;         // words held, 0..2
      logic [WIDTH-1:0] head;    // word at the drain side
      logic [WIDTH-1:0] tail;    // second word
   } buf_state_t;

   buf_state_t state;
   buf_state_t next_state;
   logic push;
   logic pop;

   // handshake terms
   assign o_ready = (state.count != 2'h2);
   assign o_valid = (state.count != 2'h0);
   assign o_data = state.head;
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_state = state;
      if (pop) begin
         // advance the tail into the head
         next_state.head = state.tail;
      end
      if (push) begin
         // new word lands in the first free slot after any pop
         if ((state.count == 2'h0) || (pop && state.count == 2'h1)) begin
            next_state.head = i_data;
         end else begin
            next_state.tail = i_data;
         end
      end
      next_state.count = 2'(state.count + {1'b0, push} - {1'b0, pop});
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule // skid_buffer

// *** design/serial_led_sink_driver_logic.sv ***
`timescale 1ns/1ps
module serial_led_sink_driver_logic #(
   parameter int unsigned CHANNELS = led_sink_pkg::CHANNELS
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_shift_clock,
   input wire logic i_serial_in,
   input wire logic i_latch_strobe,
   input wire logic i_gate_n,
   output logic o_serial_cascade_out,
   output logic [CHANNELS-1:0] o_sink_channels,
   output logic o_shift_ready
);
   localparam int unsigned STEP = led_sink_pkg::STAGGER_STEP_CYC;
   localparam int unsigned SLOTS = CHANNELS;

   // all state in one struct
   typedef struct packed {
      logic shift_clock_prev;                 // last sampled shift clock level
      logic [CHANNELS-1:0] shift;             // stage CHANNELS-1 is the oldest
      logic [CHANNELS-1:0] latch;             // latched channel pattern
      logic cascade;                          // cascade output flop
      logic [CHANNELS-1:0] target;            // gated pattern being rolled out
      logic [CHANNELS-1:0] drive;             // channels driven now
      logic [4:0] slot;                       // next slot of the stagger walk
      logic [7:0] step_cnt;                   // cycles left in the current step
   } core_state_t;

   core_state_t state;
   core_state_t next_state;
   logic shift_edge;
   logic buf_valid;
   logic [CHANNELS-1:0] buf_data;
   logic [CHANNELS-1:0] gated;

   // maps a stagger slot onto the channel it switches
   function automatic logic [3:0] slot_channel(input logic [4:0] slot);
      slot_channel = led_sink_pkg::STAGGER_ORDER[slot[3:0]];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // shift edge detect on the synchronous shift clock input
   assign shift_edge = i_shift_clock && !state.shift_clock_prev;
   // ready is tied high, though the buffer can fill while a stagger walk holds off its drain
   assign o_shift_ready = 1'b1;

   // latched pattern passes through the buffer toward the stagger stage
   skid_buffer #(
      .WIDTH(CHANNELS)
   ) u_buf (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_valid(state.latch != gated || state.slot == 5'h0),
      .o_ready(),
      .i_data(state.latch),
      .o_valid(buf_valid),
      .i_ready(state.slot == 5'(SLOTS) || state.slot == 5'h0),
      .o_data(buf_data)
   );

   // gate forces every channel off, leaving shift and latch alone
   assign gated = i_gate_n ? '0 : buf_data;

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_state = state;
      next_state.shift_clock_prev = i_shift_clock;
      if (shift_edge) begin
         // newest bit enters stage 0, oldest sits at the top
         next_state.shift = {state.shift[CHANNELS-2:0], i_serial_in};
         // cascade shows the bit that just left the top stage
         next_state.cascade = state.shift[CHANNELS-1];
      end
      // strobe high: transparent; low: hold
      if (i_latch_strobe) begin
         next_state.latch = next_state.shift;
      end
      // a changed target restarts the stagger walk
      if (buf_valid && (gated != state.target)) begin
         next_state.target = gated;
         next_state.slot = 5'h0;
         next_state.step_cnt = 8'h0;
      end else if (state.slot != 5'(SLOTS)) begin
         if (state.step_cnt == 8'h0) begin
            // switch one channel, then wait one step
            next_state.drive[slot_channel(state.slot)] =
               state.target[slot_channel(state.slot)];
            next_state.slot = 5'(state.slot + 5'h1);
            next_state.step_cnt = 8'(STEP - 1);
         end else begin
            next_state.step_cnt = 8'(state.step_cnt - 8'h1);
         end
      end
      // gate off acts on every channel at once
      if (i_gate_n) begin
         next_state.drive = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs from flops
   assign o_serial_cascade_out = state.cascade;
   assign o_sink_channels = state.drive;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state <= '0;
         state.shift <= led_sink_pkg::SHIFT_RESET;
         state.latch <= led_sink_pkg::LATCH_RESET;
         state.slot <= 5'(SLOTS);
      end else begin
         state <= next_state;
      end
   end
endmodule // serial_led_sink_driver_logic

// *** tb/led_sink_checker.sv ***
`timescale 1ns/1ps
// port checker of the sink core
module led_sink_checker #(
   parameter int unsigned CHANNELS = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_shift_clock,
   input wire logic i_latch_strobe,
   input wire logic i_gate_n,
   input wire logic o_serial_cascade_out,
   input wire logic [CHANNELS-1:0] o_sink_channels,
   input wire logic o_shift_ready
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // cycles since latch or gate last moved
   logic [7:0] quiet;
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || i_latch_strobe || ($past(i_gate_n) != i_gate_n)) begin
         quiet <= 8'h00;
      end else if (quiet != 8'hFF) begin
         quiet <= quiet + 8'h01;
      end
   end
   a_ready_high: assert property (o_shift_ready) else $error("ready low");
   a_reset_clear: assert property ($past(i_sys_rst) |-> o_sink_channels == '0
      && !o_serial_cascade_out) else $error("not clear after reset");
   a_gate_off: assert property (i_gate_n |=> o_sink_channels == '0) else $error("gate");
   a_gate_fall: assert property ($fell(i_gate_n) |-> o_sink_channels == '0)
      else $error("on before gate fall");
   a_cascade_still: assert property (!$rose(i_shift_clock) |=>
      $stable(o_serial_cascade_out)) else $error("cascade moved");
   a_one_step: assert property ((!i_gate_n && !$past(i_gate_n)) |->
      $countones(o_sink_channels ^ $past(o_sink_channels)) <= 1) else $error("burst");
   a_hold_quiet: assert property (quiet > 8'h1E |-> $stable(o_sink_channels))
      else $error("moved while held");
   a_gate_stay: assert property (i_gate_n [*3] |-> $stable(o_sink_channels))
      else $error("moved while gated");
endmodule // led_sink_checker
bind serial_led_sink_driver_logic led_sink_checker #(.CHANNELS(CHANNELS)) u_led_sink_checker (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_shift_clock(i_shift_clock),
   .i_latch_strobe(i_latch_strobe), .i_gate_n(i_gate_n), .o_shift_ready(o_shift_ready),
   .o_serial_cascade_out(o_serial_cascade_out), .o_sink_channels(o_sink_channels));

// *** tb/led_controller_model.sv ***
`timescale 1ns/1ps
// display controller: shifts one frame, then pulses the strobe
module led_controller_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] frame,
   input wire logic [3:0] half,
   output logic sclk,
   output logic sdata,
   output logic strobe,
   output logic done
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      strobe = 1'b0;
      done = 1'b0;
   end
   always @(posedge clk) if (go) begin
      for (int i = 15; i >= 0; i--) begin // channel 15 first
         sdata <= frame[i];
         repeat (half) @(posedge clk);
         sclk <= 1'b1; // half period of five cycles or more
         repeat (half) @(posedge clk);
         sclk <= 1'b0;
      end
      strobe <= 1'b1;
      sdata <= ~frame[0]; // data no longer held
      @(posedge clk);
      strobe <= 1'b0;
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
   end
endmodule // led_controller_model

// *** tb/serial_led_sink_driver_logic_tb_top.sv ***
`timescale 1ns/1ps
module serial_led_sink_driver_logic_tb_top;
   logic clk, rst, gate_n, go, look, sclk, sdata, strobe, done, casc, rdy, cas;
   logic [15:0] chans, frame, held;
   logic [3:0] half;
   logic [16:0] q[$];
   int fail_count, total_checks;
   serial_led_sink_driver_logic u_serial_led_sink_driver_logic (.i_sys_clk(clk), .i_sys_rst(rst),
      .i_shift_clock(sclk), .i_serial_in(sdata), .i_latch_strobe(strobe), .i_gate_n(gate_n),
      .o_serial_cascade_out(casc), .o_sink_channels(chans), .o_shift_ready(rdy));
   led_controller_model u_led_controller_model (.clk(clk), .go(go), .frame(frame), .half(half),
      .sclk(sclk), .sdata(sdata), .strobe(strobe), .done(done));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one frame; cascade ends on bit 0 of the frame before
   task automatic send(input logic [15:0] f);
      cas = held[0];
      held = f;
      q.push_back({cas, gate_n ? 16'h0000 : f});
      frame <= f;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait (q.size() == 0);
   endtask
   task automatic gate(input logic v);
      gate_n <= v;
      q.push_back({cas, v ? 16'h0000 : held});
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
      wait (q.size() == 0);
   endtask
   // compares the settled outputs with the oldest note
   always begin
      @(posedge clk iff (done || look));
      repeat (40) @(posedge clk);
      total_checks++;
      if ({casc, chans} !== q[0]) begin
         fail_count++;
         $display("wrong value at %0t got %h expected %h", $time, {casc, chans}, q[0]);
      end
      void'(q.pop_front());
   end
   initial begin
      rst = 1'b1; gate_n = 1'b1; go = 1'b0; look = 1'b0; frame = '0; half = 4'h5;
      held = '0; cas = 1'b0; fail_count = 0; total_checks = 0;
      void'($urandom(98929));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      gate(1'b0);
      send(16'h8001);
      send(16'hFFFF);
      for (int i = 0; i < 6; i++) begin
         half <= 4'(5 + i % 5);
         send(16'($urandom));
      end
      $display("frames done");
      gate(1'b1);
      send(16'($urandom));
      for (int i = 0; i < 8; i++) begin
         gate_n <= ~gate_n;
         repeat (3) @(posedge clk);
      end
      gate(1'b0);
      $display("gate done");
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule // serial_led_sink_driver_logic_tb_top
